// >>> core/pcpg_pkg.sv
// package: register map, field layout and timing constants for the compare pulse generator
package pcpg_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WINDOW_LOW = 8'h04;
  localparam logic [7:0] REG_WINDOW_HIGH = 8'h08;
  localparam logic [7:0] REG_SPACING = 8'h0C;
  localparam logic [7:0] REG_RESOLUTION = 8'h10;
  localparam logic [7:0] REG_START = 8'h14;
  localparam logic [7:0] REG_LIST_INDEX = 8'h18;
  localparam logic [7:0] REG_LIST_DATA = 8'h1C;
  localparam logic [7:0] REG_LIST_COUNT = 8'h20;
  localparam logic [7:0] REG_EN_WIDTH = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_POSITION = 8'h2C;
  localparam logic [7:0] REG_HW_REV = 8'h30;
  // control field positions
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_LIST_BIT = 1;
  localparam int CTRL_WIDTH_LSB = 4;
  localparam int CTRL_FILTER_LSB = 8;
  localparam int CTRL_ENC_BIT = 12;
  // status field positions
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_WIN_BIT = 3;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RES_RESET = 32'h0000_0001;
  localparam logic [31:0] EN_WIDTH_RESET = 32'h0000_0001;
  localparam logic [7:0] HW_REV_DEFAULT = 8'h02;   // arbitrary revision value
  localparam logic [7:0] HW_REV_LIST_MIN = 8'h02;  // first revision with list mode
  localparam int LIST_DEPTH = 16;
  localparam int LIST_AW = 4;
  // timing: clock period and pulse widths in ns
  localparam int CLK_NS = 25;
  localparam int WIDTH_NS [4] = '{200, 1000, 2500, 10000};
  localparam int FILTER_NS [4] = '{75, 1000, 4000, 12000};
  // pulse widths round down, filter times round up, each at least one cycle
  localparam int WIDTH_CYC [4] = '{WIDTH_NS[0] / CLK_NS, WIDTH_NS[1] / CLK_NS,
                                   WIDTH_NS[2] / CLK_NS, WIDTH_NS[3] / CLK_NS};
  localparam int FILTER_CYC [4] = '{(FILTER_NS[0] + CLK_NS - 1) / CLK_NS,
                                    (FILTER_NS[1] + CLK_NS - 1) / CLK_NS,
                                    (FILTER_NS[2] + CLK_NS - 1) / CLK_NS,
                                    (FILTER_NS[3] + CLK_NS - 1) / CLK_NS};
  localparam int CNT_W = 10;
  typedef enum logic [1:0] {ENC_QUAD, ENC_SINE} pcpg_enc_t;
endpackage

// >>> core/pcpg_core.sv
// position compare pulse generator with axi4-lite register slave
//
// Notes on behaviour
// RULE1 - readback gives low, high, spacing, armed flag
// RULE2 - host arms only while group is ready
// RULE3 - host configures window before arming
// RULE4 - window high low..high, pulses each step
// RULE5 - pulse nominally 200 ns, falling edge precise
// RULE6 - window and spacing rounded to resolution
// RULE7 - quadrature resolution equals encoder count resolution
// RULE8 - sine resolution equals pitch over interpolation
// RULE9 - list mode pulses at each stored position
// RULE10 - list window starts at pulse, position width
// RULE11 - user coordinates converted to raw before compare
// RULE12 - host spaces list positions beyond overrun margin
// RULE13 - stored positions are offsets from start
// RULE14 - list mode on old revision gives error
// RULE15 - pulse width selectable, gap twice width
// RULE16 - encoder filter selectable, adds nominal delay
// RULE17 - first pulse entering from either end
// RULE18 - list status running, clears after last
// RULE19 - compare every clock cycle
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pcpg_core
  import pcpg_pkg::*;
#(
  parameter logic [7:0] HW_REV = HW_REV_DEFAULT // arbitrary revision value
) (
  input wire logic aclk, // 40 mhz clock
  input wire logic aresetn, // sync reset, low active
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [31:0] raw_position, // raw encoder count, async
  output logic trigger_pulse, // compare trigger pulse
  output logic enable_window // compare enable window
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // round to nearest multiple of the trigger resolution
  function automatic logic [31:0] round_res(input logic [31:0] v, input logic [31:0] r);
    logic [31:0] rr;
    rr = (r == 32'h0000_0000) ? 32'h0000_0001 : r;
    return ((v + (rr >> 1)) / rr) * rr;
  endfunction
  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (d & m);
  endfunction

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [31:0] ctrl, win_low, win_high, spacing, resol, start_pos, en_width;
  logic [31:0] next_ctrl, next_win_low, next_win_high, next_spacing, next_resol;
  logic [31:0] next_start_pos, next_en_width;
  logic [LIST_AW-1:0] list_idx, next_list_idx, list_cnt, next_list_cnt, fire_idx, next_fire_idx;
  logic [31:0] list_mem [LIST_DEPTH];
  logic [31:0] next_list_mem [LIST_DEPTH];
  logic running, next_running, err, next_err;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid, next_arready, next_awready, next_wready;
  logic [31:0] next_rdata;
  logic [1:0] next_bresp, next_rresp;
  // position path
  logic [31:0] pos_s1, pos_s2, pos_f, next_pos_f, pos_prev, filt_cand, next_filt_cand;
  logic [CNT_W-1:0] filt_cnt, next_filt_cnt, pw_cnt, next_pw_cnt;
  logic [31:0] target, win_end, next_win_end;
  logic in_win, next_trigger, next_enable, fire;

  // rounded window, resolution chosen by encoder kind in resol
  logic [31:0] r_low, r_high, r_step;
  logic armed, list_mode;
  assign armed = ctrl[CTRL_ARM_BIT];
  assign list_mode = ctrl[CTRL_LIST_BIT];
  // resol holds count resolution (quad) or pitch/factor (sine), written by host
  assign r_low = round_res(win_low, resol);   // [RULE6] [RULE7] [RULE8]
  assign r_high = round_res(win_high, resol); // [RULE6]
  assign r_step = round_res(spacing, resol);  // [RULE6]

  // ------------------------------------------------------------
  // bus slave: write and read channels
  // ------------------------------------------------------------
  logic do_write;
  logic [31:0] wval;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_win_low = win_low;
    next_win_high = win_high;
    next_spacing = spacing;
    next_resol = resol;
    next_start_pos = start_pos;
    next_en_width = en_width;
    next_list_idx = list_idx;
    next_list_cnt = list_cnt;
    next_list_mem = list_mem;
    next_err = err;
    next_running = running;
    wval = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // list run ends after its last stored pulse
    if (running && fire && list_mode && (fire_idx + 1'b1 >= list_cnt)) begin
      next_running = 1'b0; // [RULE18]
      next_ctrl[CTRL_ARM_BIT] = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'b00;
      case (aw_addr)
        REG_CTRL: begin
          wval = merge(ctrl, w_data, w_strb);
          // list mode refused on old revision, arm dropped, error flagged
          if (wval[CTRL_LIST_BIT] && (HW_REV < HW_REV_LIST_MIN)) begin
            wval[CTRL_ARM_BIT] = 1'b0; // [RULE14]
            wval[CTRL_LIST_BIT] = 1'b0;
            next_err = 1'b1;
            next_bresp = 2'b10;
          end
          next_ctrl = wval;
          next_running = wval[CTRL_ARM_BIT] && wval[CTRL_LIST_BIT] && (list_cnt != 0);
        end
        REG_WINDOW_LOW: next_win_low = merge(win_low, w_data, w_strb);
        REG_WINDOW_HIGH: next_win_high = merge(win_high, w_data, w_strb);
        REG_SPACING: next_spacing = merge(spacing, w_data, w_strb);
        REG_RESOLUTION: next_resol = merge(resol, w_data, w_strb);
        REG_START: next_start_pos = merge(start_pos, w_data, w_strb);
        REG_EN_WIDTH: next_en_width = merge(en_width, w_data, w_strb);
        REG_LIST_INDEX: next_list_idx = w_data[LIST_AW-1:0];
        REG_LIST_DATA: begin
          next_list_mem[list_idx] = merge(list_mem[list_idx], w_data, w_strb);
          next_list_idx = list_idx + 1'b1;
        end
        REG_LIST_COUNT: next_list_cnt = w_data[LIST_AW-1:0];
        REG_STATUS: next_err = next_err & ~w_data[STAT_ERR_BIT];
        default: next_bresp = 2'b10;
      endcase
    end
    // ready comes from a flop: it tracks the next held state and response
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // read channel: one read at a time, data one cycle after address
  always_comb begin
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      case (s_axi_araddr)
        REG_CTRL: next_rdata = ctrl;
        REG_WINDOW_LOW: next_rdata = r_low;   // [RULE1]
        REG_WINDOW_HIGH: next_rdata = r_high; // [RULE1]
        REG_SPACING: next_rdata = r_step;     // [RULE1]
        REG_RESOLUTION: next_rdata = resol;
        REG_START: next_rdata = start_pos;
        REG_EN_WIDTH: next_rdata = en_width;
        REG_LIST_INDEX: next_rdata = {{(32-LIST_AW){1'b0}}, list_idx};
        REG_LIST_DATA: next_rdata = list_mem[list_idx];
        REG_LIST_COUNT: next_rdata = {{(32-LIST_AW){1'b0}}, list_cnt};
        REG_STATUS: next_rdata = {28'h000_0000, enable_window, err, running, armed}; // [RULE1]
        REG_POSITION: next_rdata = pos_f;
        REG_HW_REV: next_rdata = {24'h00_0000, HW_REV};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'b10;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // encoder filter and compare
  // ------------------------------------------------------------
  // a new count must hold for the filter time before it is used, so
  // chatter around one count does not double-fire; adds that delay
  logic [1:0] fsel, wsel;
  assign fsel = ctrl[CTRL_FILTER_LSB +: 2];
  assign wsel = ctrl[CTRL_WIDTH_LSB +: 2];
  always_comb begin
    next_filt_cand = filt_cand;
    next_filt_cnt = filt_cnt;
    next_pos_f = pos_f;
    if (pos_s2 != filt_cand) begin
      next_filt_cand = pos_s2;
      next_filt_cnt = '0;
    end else if (filt_cnt + 1'b1 >= CNT_W'(FILTER_CYC[fsel])) begin
      next_pos_f = filt_cand; // [RULE16]
    end else begin
      next_filt_cnt = filt_cnt + 1'b1;
    end
  end

  // spaced: fire on crossing any grid point low + k*step within window,
  // from either direction; list: fire on crossing start + offset
  logic [31:0] lo_b, hi_b, rel_p, rel_c, up_p, up_c, step_nz;
  assign step_nz = (r_step == 32'h0000_0000) ? 32'h0000_0001 : r_step;
  assign in_win = (pos_f >= r_low) && (pos_f <= r_high); // [RULE4]
  assign lo_b = (pos_prev < pos_f) ? pos_prev : pos_f;
  assign hi_b = (pos_prev < pos_f) ? pos_f : pos_prev;
  assign rel_p = (pos_prev >= r_low) ? (pos_prev - r_low) / step_nz : 32'hFFFF_FFFF;
  assign rel_c = (pos_f >= r_low) ? (pos_f - r_low) / step_nz : 32'hFFFF_FFFF;
  // ceiling indices: a falling move crosses a point in [pos_f, pos_prev)
  assign up_p = rel_p + {31'h0000_0000, (pos_prev - r_low) % step_nz != 32'h0000_0000};
  assign up_c = rel_c + {31'h0000_0000, (pos_f - r_low) % step_nz != 32'h0000_0000};
  // stored offsets added to the scan start, giving raw encoder targets
  assign target = start_pos + list_mem[fire_idx]; // [RULE11] [RULE13]
  always_comb begin
    fire = 1'b0;
    if (armed && !list_mode) begin
      // entering fires; inside, only a grid point crossed in the travel direction
      if (in_win && (pos_prev != pos_f)) begin
        if ((pos_prev < r_low) || (pos_prev > r_high)) begin
          fire = 1'b1; // [RULE17]
        end else if (pos_prev < pos_f) begin
          fire = (rel_p != rel_c); // [RULE4] [RULE19]
        end else begin
          fire = (up_p != up_c); // [RULE17] [RULE19]
        end
      end
    end else if (running && list_mode) begin
      fire = (target >= lo_b) && (target <= hi_b) && (pos_prev != pos_f); // [RULE9] [RULE19]
    end
  end

  // pulse width counter and window outputs
  always_comb begin
    next_pw_cnt = pw_cnt;
    next_trigger = trigger_pulse;
    next_fire_idx = fire_idx;
    next_win_end = win_end;
    next_enable = enable_window;
    // a fire during a live pulse is dropped; host keeps twice-width gaps
    if (fire && !trigger_pulse) begin
      next_trigger = 1'b1; // [RULE5] [RULE15]
      next_pw_cnt = CNT_W'(WIDTH_CYC[wsel] - 1);
    end else if (pw_cnt != '0) begin
      next_pw_cnt = pw_cnt - 1'b1;
    end else begin
      next_trigger = 1'b0; // falling edge timed from the clock
    end
    if (list_mode) begin
      if (fire) begin
        next_fire_idx = fire_idx + 1'b1;
        next_win_end = target + en_width;
        next_enable = 1'b1; // [RULE10]
      end else if (pos_f >= win_end || !running && !trigger_pulse) begin
        next_enable = 1'b0;
      end
    end else begin
      next_enable = armed && in_win; // [RULE4]
    end
    if (do_write && aw_addr == REG_CTRL) begin
      next_fire_idx = '0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    pos_s1 <= raw_position;
    pos_s2 <= pos_s1;
    list_mem <= next_list_mem; // no reset: entries are written before a run reads them
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      win_low <= 32'h0000_0000;
      win_high <= 32'h0000_0000;
      spacing <= 32'h0000_0000;
      resol <= RES_RESET;
      start_pos <= 32'h0000_0000;
      en_width <= EN_WIDTH_RESET;
      list_idx <= '0;
      list_cnt <= '0;
      fire_idx <= '0;
      running <= 1'b0;
      err <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      filt_cand <= 32'h0000_0000;
      filt_cnt <= '0;
      pos_f <= 32'h0000_0000;
      pos_prev <= 32'h0000_0000;
      pw_cnt <= '0;
      win_end <= 32'h0000_0000;
      trigger_pulse <= 1'b0;
      enable_window <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      win_low <= next_win_low;
      win_high <= next_win_high;
      spacing <= next_spacing;
      resol <= next_resol;
      start_pos <= next_start_pos;
      en_width <= next_en_width;
      list_idx <= next_list_idx;
      list_cnt <= next_list_cnt;
      fire_idx <= next_fire_idx;
      running <= next_running;
      err <= next_err;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      filt_cand <= next_filt_cand;
      filt_cnt <= next_filt_cnt;
      pos_f <= next_pos_f;
      pos_prev <= pos_f;
      pw_cnt <= next_pw_cnt;
      win_end <= next_win_end;
      trigger_pulse <= next_trigger;
      enable_window <= next_enable;
    end
  end

endmodule
`default_nettype wire

// >>> verification/pcpg_core_props.sv
// checker: port-level timing properties of the compare pulse generator
`timescale 1ns/10ps
`default_nettype none
module pcpg_core_props (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low active
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic trigger_pulse, // compare trigger pulse
  input wire logic enable_window // compare enable window
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // trigger output shape, default width of 8 cycles
  // ------------------------------------------------------------
  property p_width; $rose(trigger_pulse) |-> trigger_pulse [*8] ##1 !trigger_pulse; endproperty
  a_width: assert property (p_width) else $error("trigger width not 8 cycles");
  // gap after a pulse is at least its own width
  property p_gap; $fell(trigger_pulse) |-> !trigger_pulse [*8]; endproperty
  a_gap: assert property (p_gap) else $error("trigger gap too short");
  property p_win; $rose(trigger_pulse) |-> ##[0:1] enable_window; endproperty
  a_win: assert property (p_win) else $error("pulse outside enable window");
  // reset clears trigger, enable window and write response valid, checked even while reset is low
  property p_rst;
    disable iff (1'b0) !aresetn |=> !trigger_pulse && !enable_window && !s_axi_bvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  // ------------------------------------------------------------
  // register bus handshakes
  // ------------------------------------------------------------
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wblock: assert property (p_wblock) else $error("write taken while response pending");
  property p_rans; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
endmodule
bind pcpg_core pcpg_core_props chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .trigger_pulse(trigger_pulse), .enable_window(enable_window));
`default_nettype wire

// >>> verification/pcpg_stage.sv
// model of the scanning stage encoder that feeds raw counts
`timescale 1ns/10ps
`default_nettype none
module pcpg_stage #(
  parameter int STEP_CYC = 40
) (
  input wire logic aclk, // clock
  input wire logic [31:0] target, // requested count
  output logic [31:0] raw_position // encoder count
);
  int tick = 0;
  initial raw_position = 32'h0000_0000;
  // one count per STEP_CYC: slow enough that no list target is overrun
  always @(posedge aclk) begin
    tick <= (tick == STEP_CYC - 1) ? 0 : tick + 1;
    if (tick == STEP_CYC - 1 && raw_position != target) begin
      raw_position <= (raw_position < target) ? raw_position + 1 : raw_position - 1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/position_compare_pulse_gen_test.sv
// testbench: register access and compare pulse scenarios
`timescale 1ns/10ps
`default_nettype none
module position_compare_pulse_gen_test;
  import pcpg_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, trigger_pulse, enable_window, trig_q = 0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, raw_position, target = 32'h0000_0000, rd_val;
  int error_cnt = 0, check_count = 0, pulse_cnt = 0;
  always #12.5 aclk = ~aclk;
  pcpg_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .raw_position(raw_position),
    .trigger_pulse(trigger_pulse), .enable_window(enable_window));
  pcpg_stage stage_u (.aclk(aclk), .target(target), .raw_position(raw_position));
  // count rising edges of the trigger output
  always @(posedge aclk) begin
    trig_q <= trigger_pulse;
    if (trigger_pulse === 1'b1 && trig_q === 1'b0) pulse_cnt++;
  end
  // ------------------------------------------------------------
  // compare tasks
  // ------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  // ------------------------------------------------------------
  // bus tasks: hold each channel until its own handshake edge
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    chk_resp("bresp", 2'b00, bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] exp_resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd_val = rdata;
    rready <= 0;
    chk_resp("rresp", exp_resp, rresp);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a, 2'b00);
    chk_word(what, exp, rd_val);
  endtask
  // drive the stage to a count and let the filter settle
  task automatic move_to(input logic [31:0] p);
    @(posedge aclk);
    target <= p;
    do @(posedge aclk); while (raw_position !== p);
    repeat (20) @(posedge aclk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog: all motion takes under 8000 cycles
  initial begin
    #(25 * 40000);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd_chk(REG_CTRL, CTRL_RESET, "ctrl reset");
    rd_chk(REG_RESOLUTION, RES_RESET, "res reset");
    rd_chk(REG_EN_WIDTH, EN_WIDTH_RESET, "en width reset");
    rd_chk(REG_HW_REV, {24'h00_0000, HW_REV_DEFAULT}, "hw rev");
    rd_chk(REG_STATUS, 32'h0000_0000, "status reset");
    rd(8'h40, 2'b10);
    chk_word("unmapped data", 32'h0000_0000, rd_val);
    $display("test reset values done");
    // rounding to a resolution of 4 counts
    wr(REG_RESOLUTION, 32'h0000_0004);
    wr(REG_WINDOW_LOW, 32'h0000_0009);
    wr(REG_WINDOW_HIGH, 32'h0000_0017);
    wr(REG_SPACING, 32'h0000_0005);
    rd_chk(REG_WINDOW_LOW, 32'h0000_0008, "low rounded");
    rd_chk(REG_WINDOW_HIGH, 32'h0000_0018, "high rounded");
    rd_chk(REG_SPACING, 32'h0000_0004, "spacing rounded");
    $display("test rounding done");
    // spaced mode: window 10..20, step 5, configured before arming
    wr(REG_RESOLUTION, 32'h0000_0001);
    wr(REG_WINDOW_LOW, 32'h0000_000a);
    wr(REG_WINDOW_HIGH, 32'h0000_0014);
    wr(REG_SPACING, 32'h0000_0005);
    wr(REG_CTRL, 32'h0000_0001);
    rd_chk(REG_WINDOW_LOW, 32'h0000_000a, "low");
    rd_chk(REG_WINDOW_HIGH, 32'h0000_0014, "high");
    rd_chk(REG_SPACING, 32'h0000_0005, "spacing");
    rd_chk(REG_STATUS, 32'h0000_0001, "armed flag");
    move_to(32'h0000_0019);
    chk_word("pulses rising", 32'd3, pulse_cnt);
    chk_word("window past high", 32'd0, {31'd0, enable_window});
    move_to(32'h0000_0000);
    chk_word("pulses falling", 32'd6, pulse_cnt);
    rd_chk(REG_POSITION, 32'h0000_0000, "position");
    $display("test spaced mode done");
    // list mode: offsets 4 and 9 from start 100
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_START, 32'h0000_0064);
    wr(REG_LIST_INDEX, 32'h0000_0000);
    wr(REG_LIST_DATA, 32'h0000_0004);
    wr(REG_LIST_DATA, 32'h0000_0009);
    wr(REG_LIST_COUNT, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_0003);
    rd(REG_STATUS, 2'b00);
    chk_word("running", 32'd1, {31'd0, rd_val[STAT_RUN_BIT]});
    pulse_cnt = 0;
    move_to(32'h0000_0073);
    chk_word("list pulses", 32'd2, pulse_cnt);
    rd(REG_STATUS, 2'b00);
    chk_word("run cleared", 32'd0, {31'd0, rd_val[STAT_RUN_BIT]});
    $display("test list mode done");
    complete_run();
  end
endmodule
`default_nettype wire
